// File: light_prox_pkg.sv
`default_nettype none

package light_prox_pkg;

  // fixed seven-bit slave address on the serial bus
  localparam logic [6:0] DEV_ADDR = 7'h13;

  // register window on the bus, one byte each
  localparam logic [7:0] REG_FIRST = 8'h80;
  localparam logic [7:0] REG_LAST = 8'h8b;
  localparam int REG_COUNT = 12;

  // register indices (bus address minus the window base)
  localparam logic [3:0] IDX_CMD = 4'h0;
  localparam logic [3:0] IDX_ID = 4'h1;
  localparam logic [3:0] IDX_SPARE = 4'h2;
  localparam logic [3:0] IDX_LED = 4'h3;
  localparam logic [3:0] IDX_AMB_PAR = 4'h4;
  localparam logic [3:0] IDX_LIGHT_HI = 4'h5;
  localparam logic [3:0] IDX_LIGHT_LO = 4'h6;
  localparam logic [3:0] IDX_DIST_HI = 4'h7;
  localparam logic [3:0] IDX_DIST_LO = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'hb;

  // registers that software may overwrite and read back as stored
  localparam logic [11:0] RW_MASK = 12'he18;

  // command register field positions
  localparam int CMD_LOCK_BIT = 7;
  localparam int CMD_LIGHT_RDY_BIT = 6;
  localparam int CMD_DIST_RDY_BIT = 5;
  localparam int CMD_LIGHT_START_BIT = 4;
  localparam int CMD_DIST_START_BIT = 3;

  // measurement channel numbering for the ready tracker
  localparam int CH_LIGHT = 0;
  localparam int CH_DIST = 1;

  // values after reset
  localparam logic [7:0] LED_RESET = 8'h02;
  localparam logic [7:0] STORE_RESET = 8'h00;

  // product/revision byte: arbitrary neutral value
  localparam logic [7:0] ID_VALUE = 8'h5a;

  // transaction states, gray steps along the usual write path and the read byte/ack loop
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB = 4'h2,
    ST_SUB_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RACK = 4'hc,
    ST_IGNORE = 4'hd
  } bus_state_type;

endpackage : light_prox_pkg

`default_nettype wire

// File: i2c_line_monitor.sv
`default_nettype none

// samples the two bus lines and reports edges and bus conditions
module i2c_line_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic sda_level
);

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } mon_type;

  mon_type st_reg;
  mon_type st_next;

  // a data change while the clock stays high is a start or a stop
  always_comb
  begin
    st_next.scl_q = scl;
    st_next.sda_q = sda;
    st_next.rise = scl & ~st_reg.scl_q;
    st_next.fall = ~scl & st_reg.scl_q;
    st_next.start = scl & st_reg.scl_q & ~sda & st_reg.sda_q;
    st_next.stop = scl & st_reg.scl_q & sda & ~st_reg.sda_q;
  end

  // idle bus is high on both lines, so reset there to avoid a false clock rise or stop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '{scl_q: 1'b1, sda_q: 1'b1, default: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign scl_rise = st_reg.rise;
  assign scl_fall = st_reg.fall;
  assign start_seen = st_reg.start;
  assign stop_seen = st_reg.stop;
  assign sda_level = st_reg.sda_q;

endmodule : i2c_line_monitor

`default_nettype wire

// File: measure_ready_tracker.sv
`default_nettype none

// per channel: busy while converting, ready once a result has landed
module measure_ready_tracker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] start,
  input wire logic [1:0] done,
  input wire logic [1:0] clear,
  output logic [1:0] busy,
  output logic [1:0] ready
);

  typedef struct packed {
    logic [1:0] busy;
    logic [1:0] ready;
  } track_type;

  track_type st_reg;
  track_type st_next;
  wire logic [1:0] busy_nx;
  wire logic [1:0] ready_nx;

  // a result landing in the same cycle as a read-clear keeps the flag set
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      assign busy_nx[ch] = start[ch] | (st_reg.busy[ch] & ~done[ch]);
      assign ready_nx[ch] = done[ch] | (st_reg.ready[ch] & ~clear[ch]);
    end
  endgenerate

  // gather the per-channel next values into the state copy
  always_comb
  begin
    st_next.busy = busy_nx;
    st_next.ready = ready_nx;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign ready = st_reg.ready;

endmodule : measure_ready_tracker

`default_nettype wire

// File: light_prox_command.sv
`default_nettype none

module light_prox_command (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic light_start,
  output logic distance_start,
  input wire logic light_done,
  input wire logic distance_done,
  input wire logic [15:0] light_result,
  input wire logic [15:0] distance_result
);

  typedef struct packed {
    light_prox_pkg::bus_state_type fsm;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic full;
    logic read_dir;
    logic ack_in;
    logic [3:0] ptr;
    logic [7:0] tx;
    logic [light_prox_pkg::REG_COUNT-1:0][7:0] mem;
    logic drive;
    logic line_out;
    logic light_go;
    logic dist_go;
    logic [1:0] clear;
  } state_type;

  state_type st_reg;
  state_type st_next;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  logic [1:0] busy;
  logic [1:0] ready;
  logic [7:0] rd_byte;

  // edge and start/stop detection on the sampled lines
  i2c_line_monitor u_mon (
    .clk(clk),
    .arst_n(arst_n),
    .scl(scl),
    .sda(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_level(sda_level)
  );

  // conversion bookkeeping for the light and distance channels
  measure_ready_tracker u_track (
    .clk(clk),
    .arst_n(arst_n),
    .start({st_reg.dist_go, st_reg.light_go}),
    .done({distance_done, light_done}),
    .clear(st_reg.clear),
    .busy(busy),
    .ready(ready)
  );

  // byte the pointer selects; start bits read back as conversion busy
  always_comb
  begin
    rd_byte = st_reg.mem[st_reg.ptr];
    if (st_reg.ptr == light_prox_pkg::IDX_CMD)
    begin
      rd_byte = 8'h00;
      rd_byte[light_prox_pkg::CMD_LOCK_BIT] = 1'b1;
      rd_byte[light_prox_pkg::CMD_LIGHT_RDY_BIT] = ready[light_prox_pkg::CH_LIGHT];
      rd_byte[light_prox_pkg::CMD_DIST_RDY_BIT] = ready[light_prox_pkg::CH_DIST];
      rd_byte[light_prox_pkg::CMD_LIGHT_START_BIT] = busy[light_prox_pkg::CH_LIGHT];
      rd_byte[light_prox_pkg::CMD_DIST_START_BIT] = busy[light_prox_pkg::CH_DIST];
    end
    else if (st_reg.ptr == light_prox_pkg::IDX_ID)
    begin
      rd_byte = light_prox_pkg::ID_VALUE;
    end
    else if (st_reg.ptr == light_prox_pkg::IDX_SPARE)
    begin
      rd_byte = 8'h00;
    end
    else if (st_reg.ptr == light_prox_pkg::IDX_LIGHT_HI)
    begin
      rd_byte = light_result[15:8];
    end
    else if (st_reg.ptr == light_prox_pkg::IDX_LIGHT_LO)
    begin
      rd_byte = light_result[7:0];
    end
    else if (st_reg.ptr == light_prox_pkg::IDX_DIST_HI)
    begin
      rd_byte = distance_result[15:8];
    end
    else if (st_reg.ptr == light_prox_pkg::IDX_DIST_LO)
    begin
      rd_byte = distance_result[7:0];
    end
  end

  // next register index; the window wraps so the pointer never leaves it
  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    next_ptr = (p == light_prox_pkg::IDX_LAST) ? 4'h0 : 4'(p + 4'h1);
  endfunction : next_ptr

  // load the selected byte, drive its first bit, and clear the matching
  // ready flag; the flag clears as the byte is captured, not when acked
  function automatic state_type load_read(input state_type s, input logic [7:0] b);
    state_type r;
    r = s;
    r.tx = b;
    r.drive = ~b[7];
    r.fsm = light_prox_pkg::ST_RDATA;
    r.cnt = 3'h0;
    r.full = 1'b0;
    r.clear[light_prox_pkg::CH_LIGHT] = (s.ptr == light_prox_pkg::IDX_LIGHT_HI)
      || (s.ptr == light_prox_pkg::IDX_LIGHT_LO);
    r.clear[light_prox_pkg::CH_DIST] = (s.ptr == light_prox_pkg::IDX_DIST_HI)
      || (s.ptr == light_prox_pkg::IDX_DIST_LO);
    r.ptr = next_ptr(s.ptr);
    load_read = r;
  endfunction : load_read

  // store a received data byte; command writes only fire start pulses
  function automatic state_type commit(input state_type s);
    state_type r;
    r = s;
    if (s.ptr == light_prox_pkg::IDX_CMD)
    begin
      r.light_go = s.shift[light_prox_pkg::CMD_LIGHT_START_BIT];
      r.dist_go = s.shift[light_prox_pkg::CMD_DIST_START_BIT];
    end
    else if (light_prox_pkg::RW_MASK[s.ptr])
    begin
      r.mem[s.ptr] = s.shift;
    end
    r.ptr = next_ptr(s.ptr);
    commit = r;
  endfunction : commit

  // bus transaction engine: bits are taken on clock rise and the data
  // line only changes on clock fall, so start/stop never get faked
  always_comb
  begin
    st_next = st_reg;
    st_next.light_go = 1'b0;
    st_next.dist_go = 1'b0;
    st_next.clear = 2'b00;
    st_next.line_out = 1'b0;
    if (start_seen)
    begin
      // a repeated start restarts addressing from any state
      st_next.fsm = light_prox_pkg::ST_ADDR;
      st_next.cnt = 3'h0;
      st_next.full = 1'b0;
      st_next.drive = 1'b0;
    end
    else if (stop_seen)
    begin
      st_next.fsm = light_prox_pkg::ST_IDLE;
      st_next.drive = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_reg.fsm == light_prox_pkg::ST_RACK)
      begin
        st_next.ack_in = sda_level;
      end
      else if ((st_reg.fsm == light_prox_pkg::ST_ADDR)
        || (st_reg.fsm == light_prox_pkg::ST_SUB)
        || (st_reg.fsm == light_prox_pkg::ST_WDATA)
        || (st_reg.fsm == light_prox_pkg::ST_RDATA))
      begin
        // msb first; one sample per rise keeps up with high-speed clocks
        st_next.shift = {st_reg.shift[6:0], sda_level};
        st_next.cnt = 3'(st_reg.cnt + 3'h1);
        st_next.full = (st_reg.cnt == 3'h7);
      end
    end
    else if (scl_fall)
    begin
      case (st_reg.fsm)
        light_prox_pkg::ST_ADDR:
        begin
          if (st_reg.full)
          begin
            st_next.full = 1'b0;
            st_next.cnt = 3'h0;
            if (st_reg.shift[7:1] == light_prox_pkg::DEV_ADDR)
            begin
              st_next.drive = 1'b1;
              st_next.read_dir = st_reg.shift[0];
              st_next.fsm = light_prox_pkg::ST_ADDR_ACK;
            end
            else
            begin
              st_next.fsm = light_prox_pkg::ST_IGNORE;
            end
          end
        end
        light_prox_pkg::ST_ADDR_ACK:
        begin
          if (st_reg.read_dir)
          begin
            st_next = load_read(st_next, rd_byte);
          end
          else
          begin
            st_next.drive = 1'b0;
            st_next.fsm = light_prox_pkg::ST_SUB;
          end
        end
        light_prox_pkg::ST_SUB:
        begin
          if (st_reg.full)
          begin
            st_next.full = 1'b0;
            st_next.cnt = 3'h0;
            // addresses outside the window are not acknowledged
            if ((st_reg.shift >= light_prox_pkg::REG_FIRST)
              && (st_reg.shift <= light_prox_pkg::REG_LAST))
            begin
              st_next.ptr = st_reg.shift[3:0];
              st_next.drive = 1'b1;
              st_next.fsm = light_prox_pkg::ST_SUB_ACK;
            end
            else
            begin
              st_next.fsm = light_prox_pkg::ST_IGNORE;
            end
          end
        end
        light_prox_pkg::ST_SUB_ACK:
        begin
          st_next.drive = 1'b0;
          st_next.fsm = light_prox_pkg::ST_WDATA;
        end
        light_prox_pkg::ST_WDATA:
        begin
          if (st_reg.full)
          begin
            st_next = commit(st_next);
            st_next.full = 1'b0;
            st_next.cnt = 3'h0;
            st_next.drive = 1'b1;
            st_next.fsm = light_prox_pkg::ST_WDATA_ACK;
          end
        end
        light_prox_pkg::ST_WDATA_ACK:
        begin
          st_next.drive = 1'b0;
          st_next.fsm = light_prox_pkg::ST_WDATA;
        end
        light_prox_pkg::ST_RDATA:
        begin
          if (st_reg.full)
          begin
            // release the line so the host can answer the byte
            st_next.drive = 1'b0;
            st_next.full = 1'b0;
            st_next.cnt = 3'h0;
            st_next.fsm = light_prox_pkg::ST_RACK;
          end
          else
          begin
            st_next.tx = {st_reg.tx[6:0], 1'b0};
            st_next.drive = ~st_reg.tx[6];
          end
        end
        light_prox_pkg::ST_RACK:
        begin
          if (!st_reg.ack_in)
          begin
            st_next = load_read(st_next, rd_byte);
          end
          else
          begin
            st_next.drive = 1'b0;
            st_next.fsm = light_prox_pkg::ST_IGNORE;
          end
        end
        default:
        begin
          st_next.drive = 1'b0;
        end
      endcase
    end
  end

  // one register for all state; stored bytes start at their reset values
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
      st_reg.fsm <= light_prox_pkg::ST_IDLE;
      st_reg.ack_in <= 1'b1;
      st_reg.mem <= {light_prox_pkg::REG_COUNT{light_prox_pkg::STORE_RESET}};
      st_reg.mem[light_prox_pkg::IDX_LED] <= light_prox_pkg::LED_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // open drain: only ever pull low, the pull-up makes the high level
  assign sda_out = st_reg.line_out;
  assign sda_oe = st_reg.drive;
  assign light_start = st_reg.light_go;
  assign distance_start = st_reg.dist_go;

endmodule : light_prox_command

`default_nettype wire

// File: light_prox_checker.sv
`default_nettype none

module light_prox_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic light_start,
  input wire logic distance_start,
  input wire logic light_done,
  input wire logic distance_done,
  input wire logic [15:0] light_result,
  input wire logic [15:0] distance_result
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // open drain: the pin is only ever pulled low
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  light_pulse_a: assert property (light_start |=> !light_start)
    else $error("light start longer than one cycle");
  dist_pulse_a: assert property (distance_start |=> !distance_start)
    else $error("distance start longer than one cycle");
  // a start comes with the ack of the data byte, in the scl low phase
  light_on_ack_a: assert property (light_start |-> sda_oe && !scl)
    else $error("light start outside data ack");
  dist_on_ack_a: assert property (distance_start |-> sda_oe && !scl)
    else $error("distance start outside data ack");
  // a change while scl is high would be a false start or stop
  data_steady_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*2])
    else $error("pull-down too short");
  reset_quiet_a: assert property ($rose(arst_n) |-> !sda_oe && !light_start)
    else $error("activity right after reset");

  both_start_c: cover property (light_start && distance_start);
  ack_c: cover property ($rose(sda_oe));
  light_done_c: cover property (light_done);
  dist_done_c: cover property (distance_done);
endmodule : light_prox_checker

bind light_prox_command light_prox_checker checker_inst (
  .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .light_start(light_start), .distance_start(distance_start),
  .light_done(light_done), .distance_done(distance_done),
  .light_result(light_result), .distance_result(distance_result)
);

`default_nettype wire

// File: i2c_host_model.sv
`default_nettype none

module i2c_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one bit: data moves with scl low for 4 clocks, sampled mid-high
  task automatic bit_cyc(input logic b, output logic seen);
    @(posedge clk) sda_low <= ~b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    seen = sda;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
  endtask : bit_cyc

  // release first; the device lets go of its ack 2 clocks after the fall
  task automatic start_cond();
    @(posedge clk) sda_low <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_low <= 1'b1;
    repeat (3) @(posedge clk);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    @(posedge clk) sda_low <= 1'b1;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_low <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(v[i], s);
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic get_byte(input logic more, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b1, s);
      v[i] = s;
    end
    bit_cyc(~more, s);
  endtask : get_byte

  // address, register, data, each answered by the device
  task automatic wr_reg(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
                        output logic [2:0] acks);
    start_cond();
    send_byte(dev, acks[2]);
    send_byte(ra, acks[1]);
    send_byte(d, acks[0]);
    stop_cond();
  endtask : wr_reg

  // pointer write, stop, then a one-byte read ended by a nack
  task automatic rd_reg(input logic [7:0] ra, output logic [7:0] v, output logic [2:0] acks);
    start_cond();
    send_byte(8'h26, acks[2]);
    send_byte(ra, acks[1]);
    stop_cond();
    start_cond();
    send_byte(8'h27, acks[0]);
    get_byte(1'b0, v);
    stop_cond();
  endtask : rd_reg

  // pointer write, repeated start with no stop, then two bytes: first acked, last nacked
  task automatic rd_pair(input logic [7:0] ra, output logic [7:0] v0, output logic [7:0] v1,
                         output logic [2:0] acks);
    start_cond();
    send_byte(8'h26, acks[2]);
    send_byte(ra, acks[1]);
    start_cond();
    send_byte(8'h27, acks[0]);
    get_byte(1'b1, v0);
    get_byte(1'b0, v1);
    stop_cond();
  endtask : rd_pair
endmodule : i2c_host_model

`default_nettype wire

// File: light_prox_command_tb.sv
`default_nettype none

module light_prox_command_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic light_start;
  logic distance_start;
  logic light_done = 1'b0;
  logic distance_done = 1'b0;
  logic [15:0] light_result = 16'h1234;
  logic [15:0] distance_result = 16'hbeef;
  logic both_seen = 1'b0;
  logic [7:0] rv;
  logic [7:0] rv2;
  logic [2:0] ak;
  int fail_count = 0;
  int tests_run = 0;
  int conv_wait = 1;
  int lcnt = 0;
  int dcnt = 0;
  logic [7:0] sweep [12] = '{8'h80, 8'h5a, 8'h00, 8'h02, 8'h00, 8'h12,
                             8'h34, 8'hbe, 8'hef, 8'h00, 8'h00, 8'h00};
  logic [7:0] strt [4] = '{8'h10, 8'h10, 8'h08, 8'h08};
  logic [7:0] rdy [4] = '{8'h40, 8'h40, 8'h20, 8'h20};
  wire logic sda;

  // pulled-up line: low if either party pulls it
  assign sda = ~((sda_oe & ~sda_out) | sda_low);

  initial
  begin
    forever #25 clk = ~clk;
  end

  light_prox_command dut (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .light_start(light_start), .distance_start(distance_start),
    .light_done(light_done), .distance_done(distance_done),
    .light_result(light_result), .distance_result(distance_result)
  );

  i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // converter stand-in; conv_wait sets a prompt or a slow answer
  always @(posedge clk)
  begin
    light_done <= (lcnt == 1);
    distance_done <= (dcnt == 1);
    lcnt <= light_start ? conv_wait : (lcnt > 0 ? lcnt - 1 : 0);
    dcnt <= distance_start ? conv_wait : (dcnt > 0 ? dcnt - 1 : 0);
    if (light_start && distance_start)
      both_seen <= 1'b1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // every register answers with its reset or input value
    for (int i = 0; i < 12; i++)
    begin
      host.rd_reg(8'h80 + 8'(i), rv, ak);
      check({5'h00, ak}, 8'h07);
      check(rv, sweep[i]);
    end
    // foreign address and out-of-window register are refused
    host.wr_reg(8'h28, 8'h83, 8'h11, ak);
    check({5'h00, ak}, 8'h00);
    host.wr_reg(8'h26, 8'h8c, 8'h11, ak);
    check({5'h00, ak}, 8'h04);
    host.wr_reg(8'h26, 8'h82, 8'h55, ak);
    check({5'h00, ak}, 8'h07);
    host.rd_reg(8'h82, rv, ak);
    check(rv, 8'h00);
    host.wr_reg(8'h26, 8'h83, 8'h15, ak);
    host.rd_reg(8'h83, rv, ak);
    check(rv, 8'h15);
    // each result byte: start, ready shows, byte read, ready gone
    for (int i = 0; i < 4; i++)
    begin
      host.wr_reg(8'h26, 8'h80, strt[i], ak);
      repeat (20) @(posedge clk);
      host.rd_reg(8'h80, rv, ak);
      check(rv, 8'h80 | rdy[i]);
      host.rd_reg(8'h85 + 8'(i), rv, ak);
      check(rv, sweep[5 + i]);
      host.rd_reg(8'h80, rv, ak);
      check(rv, 8'h80);
    end
    // slow converter: both start together, busy, then both ready
    conv_wait = 1500;
    host.wr_reg(8'h26, 8'h80, 8'h18, ak);
    check({7'h00, both_seen}, 8'h01);
    host.rd_reg(8'h80, rv, ak);
    check(rv, 8'h98);
    repeat (1600) @(posedge clk);
    host.rd_reg(8'h80, rv, ak);
    check(rv, 8'he0);
    host.rd_reg(8'h88, rv, ak);
    check(rv, 8'hef);
    host.rd_reg(8'h80, rv, ak);
    check(rv, 8'hc0);
    // flag bits and unused bits ignore writes
    host.wr_reg(8'h26, 8'h80, 8'he7, ak);
    host.rd_reg(8'h80, rv, ak);
    check(rv, 8'hc0);
    // repeated start and a host-acked read that wraps from 8Bh back to 80h
    host.wr_reg(8'h26, 8'h8b, 8'h3c, ak);
    host.rd_pair(8'h8b, rv, rv2, ak);
    check({5'h00, ak}, 8'h07);
    check(rv, 8'h3c);
    check(rv2, 8'hc0);
    // a second reset mid-run brings stored bytes and ready flags back
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    host.rd_reg(8'h83, rv, ak);
    check(rv, 8'h02);
    host.rd_reg(8'h80, rv, ak);
    check(rv, 8'h80);
    complete_run();
  end
endmodule : light_prox_command_tb

`default_nettype wire
